/* File: hw/trc_consts.svh */
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH
`define TRC_OFF_DETECT   8'h02
`define TRC_OFF_SENS     8'h03
`define TRC_OFF_FAVG     8'h04
`define TRC_OFF_SAVG     8'h05
`define TRC_OFF_FACC     8'h06
`define TRC_OFF_SACC     8'h07
`define TRC_OFF_SPEED    8'h08
`define TRC_OFF_SLEEP    8'h0A
`define TRC_OFF_DEBOUNCE 8'h0B
`define TRC_OFF_MODE     8'h0C
`define TRC_OFF_OPTION   8'h0D
`define TRC_OFF_INSET    8'h0E
`define TRC_RST_DETECT   8'hC5
`define TRC_RST_SENS     8'h04
`define TRC_RST_FAVG     8'h04
`define TRC_RST_SAVG     8'h10
`define TRC_RST_FACC     8'h04
`define TRC_RST_SACC     8'h08
`define TRC_RST_SPEED    8'h04
`define TRC_RST_SLEEP    8'h64
`define TRC_RST_DEBOUNCE 8'h80
`define TRC_RST_MODE     8'hB1
`define TRC_RST_OPTION   8'h00
`define TRC_RST_INSET    8'h19
`define TRC_PRESS_MSB    7
`define TRC_PRESS_LSB    5
`define TRC_MOVE_MSB     4
`define TRC_MOVE_LSB     3
`define TRC_RELEASE_MSB  2
`define TRC_RELEASE_LSB  0
`define TRC_WIRE_BIT     1
`define TRC_CAL_BIT      0
`define TRC_OPTION_MASK  8'h03
`define TRC_SENS_MAX     8'h0A
`define TRC_ACC_MAX      8'h08
`define TRC_INSET_MAX    8'h28
`define TRC_CLK_MHZ      250
`define TRC_SLEEP_UNIT_US 100000
`define TRC_DEBOUNCE_UNIT_US 240
`define TRC_SLEEP_UNIT_CYC (`TRC_SLEEP_UNIT_US * `TRC_CLK_MHZ)
`define TRC_DEBOUNCE_UNIT_CYC (`TRC_DEBOUNCE_UNIT_US * `TRC_CLK_MHZ)
`endif

/* File: hw/trc_pkg.sv */
package trc_pkg;
   typedef enum logic [1:0] {
      TRC_IDLE    = 2'b00,
      TRC_PRESSED = 2'b01,
      TRC_DEBOUNCE = 2'b10,
      TRC_SLEEP   = 2'b11
   } trc_touch_t;

   // Register write / read request from command decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } trc_req_t;

   // One measurement step from the analog front end
   typedef struct packed {
      logic       valid;
      logic [7:0] level;
      logic [7:0] speed;
   } trc_meas_t;

   // Settings handed to the measurement engine
   typedef struct packed {
      logic [7:0] avg_count;
      logic [3:0] acc_level;
      logic [3:0] sens;
      logic       fast;
      logic       eight_wire;
      logic       cal_out;
      logic [5:0] inset;
   } trc_meas_cfg_t;
endpackage

/* File: hw/trc_report_seq.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.svh"
// Plays out a press or release report sequence of up to three reports
module trc_report_seq
   import trc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [2:0] code,
   input  wire logic       ready,
   output logic            busy,
   output logic            rpt_valid,
   output logic            rpt_pen
);
   typedef struct packed {
      logic [2:0] pens;
      logic [1:0] left;
      logic       valid;
      logic       pen;
   } trc_seq_t;

   trc_seq_t st;
   trc_seq_t next_st;

   // Pen states in emit order, and count of reports
   function automatic logic [4:0] seq_of(input logic [2:0] c);
      unique case (c)
         3'b001:  seq_of = {2'd1, 3'b000};
         3'b010:  seq_of = {2'd1, 3'b001};
         3'b011:  seq_of = {2'd2, 3'b001};
         3'b100:  seq_of = {2'd3, 3'b010};
         3'b101:  seq_of = {2'd2, 3'b010};
         default: seq_of = {2'd0, 3'b000};
      endcase
   endfunction

   // Emit one report per accepted handshake
   always_comb begin
      next_st = st;
      if (st.valid && ready) begin
         next_st.valid = 1'b0;
      end
      if (!next_st.valid && st.left != 2'd0) begin
         next_st.valid = 1'b1;
         next_st.pen   = st.pens[0];
         next_st.pens  = {1'b0, st.pens[2:1]};
         next_st.left  = st.left - 2'd1;
      end
      if (start && !busy) begin
         {next_st.left, next_st.pens} = seq_of(code);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy      = st.valid || st.left != 2'd0;
   assign rpt_valid = st.valid;
   assign rpt_pen   = st.pen;

   // Code 100 gives 0, 1, 0
   seq_three_a: assert property (@(posedge sys_clk) disable iff (rst)
      (start && !busy && code == 3'b100) |=> (st.left == 2'd3 && st.pens == 3'b010))
      else $error("three report sequence not loaded");
   seq_none_a: assert property (@(posedge sys_clk) disable iff (rst)
      (start && !busy && code == 3'b000) |=> !busy)
      else $error("empty code produced reports");
endmodule
`default_nettype wire

/* File: hw/trc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.svh"
// Touch report configuration and reporting state
module trc_top
   import trc_pkg::*;
#(
   parameter int SLEEP_UNIT_CYC    = `TRC_SLEEP_UNIT_CYC,
   parameter int DEBOUNCE_UNIT_CYC = `TRC_DEBOUNCE_UNIT_CYC
) (
   input  wire logic           sys_clk,
   input  wire logic           rst,
   input  wire trc_pkg::trc_req_t  req,
   input  wire trc_pkg::trc_meas_t meas,
   input  wire logic           calibrated,
   input  wire logic           rpt_ready,
   output logic [7:0]          rdata,
   output logic                rdata_valid,
   output logic                rpt_valid,
   output logic                rpt_pen,
   output logic                asleep,
   output trc_pkg::trc_meas_cfg_t meas_cfg
);
   import trc_pkg::*;

   typedef struct packed {
      logic [7:0]   detect;
      logic [7:0]   sens;
      logic [7:0]   favg;
      logic [7:0]   savg;
      logic [7:0]   facc;
      logic [7:0]   sacc;
      logic [7:0]   speed;
      logic [7:0]   sleep;
      logic [7:0]   debounce;
      logic [7:0]   mode;
      logic [1:0]   option;
      logic [7:0]   inset;
      trc_touch_t   touch;
      logic [31:0]  sleep_cnt;
      logic [7:0]   sleep_units;
      logic [31:0]  deb_cnt;
      logic [7:0]   deb_units;
      logic [7:0]   rdata;
      logic         rdata_valid;
      logic         move_valid;
      logic         move_pen;
      logic         asleep;
      trc_meas_cfg_t cfg;
   } trc_state_t;

   trc_state_t st;
   trc_state_t next_st;

   logic       seq_start;
   logic [2:0] seq_code;
   logic       seq_busy;
   logic       seq_valid;
   logic       seq_pen;
   logic       pressed;
   logic       fast;

   // Clamp a value to an upper limit
   function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] hi);
      clamp = (v > hi) ? hi : v;
   endfunction

   // Round an average count down to a legal power of two
   function automatic logic [7:0] pow2(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h01;
      for (int i = 7; i >= 0; i--) begin
         if (v[i] && r == 8'h01) begin
            r = 8'(1 << i);
         end
      end
      pow2 = r;
   endfunction

   // Press and speed classification of the current sample
   assign pressed = meas.valid && meas.level < st.detect;
   assign fast    = meas.speed > st.speed;

   // Register file, touch state machine and timers
   always_comb begin
      next_st = st;
      seq_start = 1'b0;
      seq_code  = 3'b000;
      next_st.rdata_valid = 1'b0;
      if (req.wr) begin
         unique case (req.addr)
            `TRC_OFF_DETECT:   next_st.detect = req.wdata;
            `TRC_OFF_SENS:     next_st.sens = clamp(req.wdata, `TRC_SENS_MAX);
            `TRC_OFF_FAVG:     next_st.favg = pow2(req.wdata);
            `TRC_OFF_SAVG:     next_st.savg = pow2(req.wdata);
            `TRC_OFF_FACC:     next_st.facc = clamp(req.wdata, `TRC_ACC_MAX);
            `TRC_OFF_SACC:     next_st.sacc = clamp(req.wdata, `TRC_ACC_MAX);
            `TRC_OFF_SPEED:    next_st.speed = req.wdata;
            `TRC_OFF_SLEEP:    next_st.sleep = req.wdata;
            `TRC_OFF_DEBOUNCE: next_st.debounce = req.wdata;
            `TRC_OFF_MODE:     next_st.mode = req.wdata;
            `TRC_OFF_OPTION:   next_st.option = req.wdata[1:0];
            `TRC_OFF_INSET:    next_st.inset = clamp(req.wdata, `TRC_INSET_MAX);
            default: ;
         endcase
      end
      if (req.rd) begin
         next_st.rdata_valid = 1'b1;
         unique case (req.addr)
            `TRC_OFF_DETECT:   next_st.rdata = st.detect;
            `TRC_OFF_SENS:     next_st.rdata = st.sens;
            `TRC_OFF_FAVG:     next_st.rdata = st.favg;
            `TRC_OFF_SAVG:     next_st.rdata = st.savg;
            `TRC_OFF_FACC:     next_st.rdata = st.facc;
            `TRC_OFF_SACC:     next_st.rdata = st.sacc;
            `TRC_OFF_SPEED:    next_st.rdata = st.speed;
            `TRC_OFF_SLEEP:    next_st.rdata = st.sleep;
            `TRC_OFF_DEBOUNCE: next_st.rdata = st.debounce;
            `TRC_OFF_MODE:     next_st.rdata = st.mode;
            `TRC_OFF_OPTION:   next_st.rdata = {6'h00, st.option};
            `TRC_OFF_INSET:    next_st.rdata = st.inset;
            default:           next_st.rdata = 8'h00;
         endcase
      end

      // Movement stream handshake
      if (st.move_valid && rpt_ready) begin
         next_st.move_valid = 1'b0;
      end

      // Idle timer: counts 100 ms units without activity
      if (req.wr || req.rd || pressed) begin
         next_st.sleep_cnt   = '0;
         next_st.sleep_units = 8'h00;
      end else if (st.touch == TRC_IDLE && st.sleep != 8'h00) begin
         if (st.sleep_cnt == 32'(SLEEP_UNIT_CYC - 1)) begin
            next_st.sleep_cnt   = '0;
            next_st.sleep_units = st.sleep_units + 8'h01;
         end else begin
            next_st.sleep_cnt = st.sleep_cnt + 32'h1;
         end
      end

      unique case (st.touch)
         TRC_IDLE: begin
            if (pressed && !seq_busy) begin
               next_st.touch = TRC_PRESSED;
               seq_start = 1'b1;
               seq_code  = st.mode[`TRC_PRESS_MSB:`TRC_PRESS_LSB];
            end else if (st.sleep != 8'h00 && next_st.sleep_units >= st.sleep) begin
               next_st.touch = TRC_SLEEP;
            end
         end
         TRC_PRESSED: begin
            if (!meas.valid) begin
            end else if (!pressed) begin
               next_st.touch     = TRC_DEBOUNCE;
               next_st.deb_cnt   = '0;
               next_st.deb_units = 8'h00;
            end else if (!seq_busy && !st.move_valid) begin
               unique case (st.mode[`TRC_MOVE_MSB:`TRC_MOVE_LSB])
                  2'b01: begin
                     next_st.move_valid = 1'b1;
                     next_st.move_pen   = 1'b0;
                  end
                  2'b10: begin
                     next_st.move_valid = 1'b1;
                     next_st.move_pen   = 1'b1;
                  end
                  default: ;
               endcase
            end
         end
         TRC_DEBOUNCE: begin
            if (pressed) begin
               next_st.touch = TRC_PRESSED;
            end else if (st.deb_units >= st.debounce) begin
               if (!seq_busy && !st.move_valid) begin
                  next_st.touch = TRC_IDLE;
                  seq_start = 1'b1;
                  seq_code  = st.mode[`TRC_RELEASE_MSB:`TRC_RELEASE_LSB];
               end
            end else if (st.deb_cnt == 32'(DEBOUNCE_UNIT_CYC - 1)) begin
               next_st.deb_cnt   = '0;
               next_st.deb_units = st.deb_units + 8'h01;
            end else begin
               next_st.deb_cnt = st.deb_cnt + 32'h1;
            end
         end
         TRC_SLEEP: begin
            if (pressed || req.wr || req.rd) begin
               next_st.touch       = pressed ? TRC_PRESSED : TRC_IDLE;
               seq_start           = pressed;
               seq_code            = st.mode[`TRC_PRESS_MSB:`TRC_PRESS_LSB];
               next_st.sleep_units = 8'h00;
            end
         end
      endcase
      next_st.asleep = next_st.touch == TRC_SLEEP;

      // Settings for the measurement engine; fast or slow set chosen per sample
      if (meas.valid) begin
         next_st.cfg.fast = fast;
      end
      next_st.cfg.avg_count  = next_st.cfg.fast ? st.favg : st.savg;
      next_st.cfg.acc_level  = next_st.cfg.fast ? st.facc[3:0] : st.sacc[3:0];
      next_st.cfg.sens       = st.sens[3:0];
      next_st.cfg.eight_wire = st.option[`TRC_WIRE_BIT];
      next_st.cfg.cal_out    = st.option[`TRC_CAL_BIT] && calibrated;
      next_st.cfg.inset      = st.inset[5:0];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st          <= '0;
         st.detect   <= `TRC_RST_DETECT;
         st.sens     <= `TRC_RST_SENS;
         st.favg     <= `TRC_RST_FAVG;
         st.savg     <= `TRC_RST_SAVG;
         st.facc     <= `TRC_RST_FACC;
         st.sacc     <= `TRC_RST_SACC;
         st.speed    <= `TRC_RST_SPEED;
         st.sleep    <= `TRC_RST_SLEEP;
         st.debounce <= `TRC_RST_DEBOUNCE;
         st.mode     <= `TRC_RST_MODE;
         st.option   <= 2'(`TRC_RST_OPTION);
         st.inset    <= `TRC_RST_INSET;
         st.touch    <= TRC_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Press and release report sequences
   trc_report_seq u_seq (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (seq_start),
      .code      (seq_code),
      .ready     (rpt_ready && !st.move_valid),
      .busy      (seq_busy),
      .rpt_valid (seq_valid),
      .rpt_pen   (seq_pen)
   );

   // Outputs from flip-flops; movement reports take the link first
   assign rdata       = st.rdata;
   assign rdata_valid = st.rdata_valid;
   assign rpt_valid   = st.move_valid || seq_valid;
   assign rpt_pen     = st.move_valid ? st.move_pen : seq_pen;
   assign asleep      = st.asleep;
   assign meas_cfg    = st.cfg;

   // Option register upper bits stay zero
   opt_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      (req.rd && req.addr == `TRC_OFF_OPTION) |=> (rdata[7:2] == 6'h00))
      else $error("option upper bits not zero");
   sleep_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st.sleep == 8'h00 && !asleep) |=> !asleep)
      else $error("slept with sleep disabled");
   wake_touch_a: assert property (@(posedge sys_clk) disable iff (rst)
      (asleep && pressed) |=> (!asleep && st.touch == TRC_PRESSED))
      else $error("touch did not wake device");
   bounce_back_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st.touch == TRC_DEBOUNCE && pressed) |=> (st.touch == TRC_PRESSED))
      else $error("contact return lost");
   release_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st.touch == TRC_DEBOUNCE && st.deb_units < st.debounce) |=> (st.touch != TRC_IDLE))
      else $error("release before debounce expired");
   move_pen_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st.touch == TRC_PRESSED && pressed && !seq_busy && !st.move_valid
       && st.mode[4:3] == 2'b10) |=> (st.move_valid && st.move_pen))
      else $error("movement report pen wrong");
   cal_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      meas_cfg.cal_out |-> $past(st.option[0] && calibrated))
      else $error("calibrated output without calibration");
   fast_pick_a: assert property (@(posedge sys_clk) disable iff (rst)
      (meas.valid && fast) |=> (meas_cfg.fast && meas_cfg.avg_count == $past(st.favg)))
      else $error("fast average not selected");
   press_det_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st.touch == TRC_IDLE && meas.valid && meas.level >= st.detect) |=>
      (st.touch != TRC_PRESSED))
      else $error("press accepted above detect level");
endmodule
`default_nettype wire

/* File: test/trc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host end of the report link: accepts reports and logs their pen states
module trc_host_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic slow,
   input  wire logic rpt_valid,
   input  wire logic rpt_pen,
   output logic      rpt_ready
);
   logic       got[$];
   logic [1:0] pace;

   // Pacing counter: a slow host accepts one cycle in three
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pace <= 2'h0;
      end else begin
         pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      end
   end

   assign rpt_ready = !rst && (!slow || pace == 2'h2);

   // Log the pen state of every accepted report
   always @(posedge sys_clk) begin
      if (!rst && rpt_valid && rpt_ready) begin
         got.push_back(rpt_pen);
      end
   end
endmodule
`default_nettype wire

/* File: test/touch_report_config_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end
// Bench for the touch report configuration block
module touch_report_config_tb_top;
   import trc_pkg::*;
   localparam int SLEEP_UNIT = 10;
   localparam int DEB_UNIT   = 4;
   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic          calibrated = 1'b0;
   logic          slow = 1'b0;
   logic          rpt_ready;
   logic          rdata_valid;
   logic          rpt_valid;
   logic          rpt_pen;
   logic          asleep;
   logic [7:0]    rdata;
   logic [7:0]    d;
   trc_req_t      req = '0;
   trc_meas_t     meas = '0;
   trc_meas_cfg_t meas_cfg;
   int            mismatches = 0;
   int            tests_run = 0;

   always #2 sys_clk = ~sys_clk;

   trc_top #(.SLEEP_UNIT_CYC(SLEEP_UNIT), .DEBOUNCE_UNIT_CYC(DEB_UNIT)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .req(req), .meas(meas), .calibrated(calibrated),
      .rpt_ready(rpt_ready), .rdata(rdata), .rdata_valid(rdata_valid),
      .rpt_valid(rpt_valid), .rpt_pen(rpt_pen), .asleep(asleep), .meas_cfg(meas_cfg));

   trc_host_model i_host (.sys_clk(sys_clk), .rst(rst), .slow(slow),
      .rpt_valid(rpt_valid), .rpt_pen(rpt_pen), .rpt_ready(rpt_ready));

   // Verdict and end of run
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Step to just after the n-th rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      tick(1);
      req = '0;
      tick(1);
   endtask

   // Read strobe; data and its one-cycle valid flag stand after the taking edge
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick(1);
      `CHK(rdata_valid, 1'b1)
      v = rdata;
      req = '0;
      tick(1);
   endtask

   task automatic sample(input logic [7:0] lvl, input logic [7:0] spd);
      meas = '{valid: 1'b1, level: lvl, speed: spd};
      tick(1);
      meas = '0;
      tick(1);
   endtask

   // Release contact and let the debounce run out
   task automatic lift();
      sample(8'hFF, 8'h00);
      tick(2 * DEB_UNIT + 20);
      i_host.got.delete();
   endtask

   task automatic wait_rpt(input int n);
      int i;
      for (i = 0; i < 3000 && i_host.got.size() < n; i++) tick(1);
      if (i_host.got.size() < n) begin
         mismatches++;
         $display("ERROR at %0t: got %0h expected %0h", $time, i_host.got.size(), n);
         conclude();
      end
   endtask

   // Expect exactly n reports, pen state of report i in bit i
   task automatic check_pens(input int n, input logic [3:0] pens);
      wait_rpt(n);
      tick(20);
      `CHK(i_host.got.size(), n)
      for (int i = 0; i < n; i++) `CHK(i_host.got[i], pens[i])
      i_host.got.delete();
   endtask

   task automatic t_reset();
      logic [7:0] offs[12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A,
                               8'h0B, 8'h0C, 8'h0D, 8'h0E};
      logic [7:0] dflt[12] = '{8'hC5, 8'h04, 8'h04, 8'h10, 8'h04, 8'h08, 8'h04, 8'h64,
                               8'h80, 8'hB1, 8'h00, 8'h19};
      for (int i = 0; i < 12; i++) begin
         reg_rd(offs[i], d);
         `CHK(d, dflt[i])
      end
      reg_rd(8'h09, d);
      `CHK(d, 8'h00)
   endtask

   task automatic t_option();
      reg_wr(`TRC_OFF_OPTION, 8'hFF);
      reg_rd(`TRC_OFF_OPTION, d);
      `CHK(d, 8'h03)
      `CHK(meas_cfg.eight_wire, 1'b1)
      `CHK(meas_cfg.cal_out, 1'b0)
      calibrated = 1'b1;
      tick(2);
      `CHK(meas_cfg.cal_out, 1'b1)
      reg_wr(`TRC_OFF_OPTION, 8'h00);
      tick(1);
      `CHK(meas_cfg.eight_wire, 1'b0)
      `CHK(meas_cfg.cal_out, 1'b0)
      reg_wr(`TRC_OFF_SENS, 8'h0A);
      tick(1);
      `CHK(meas_cfg.sens, 4'hA)
      reg_wr(`TRC_OFF_INSET, 8'h28);
      tick(1);
      `CHK(meas_cfg.inset, 6'h28)
      reg_rd(`TRC_OFF_INSET, d);
      `CHK(d, 8'h28)
   endtask

   task automatic t_speed();
      reg_wr(`TRC_OFF_MODE, 8'h00);
      reg_wr(`TRC_OFF_FAVG, 8'h08);
      reg_wr(`TRC_OFF_SAVG, 8'h20);
      reg_wr(`TRC_OFF_FACC, 8'h03);
      reg_wr(`TRC_OFF_SACC, 8'h07);
      reg_wr(`TRC_OFF_SPEED, 8'h40);
      sample(8'h10, 8'h41);
      tick(1);
      `CHK({meas_cfg.fast, meas_cfg.avg_count, meas_cfg.acc_level}, 13'h1083)
      sample(8'h10, 8'h40);
      tick(1);
      `CHK({meas_cfg.fast, meas_cfg.avg_count, meas_cfg.acc_level}, 13'h0207)
      lift();
   endtask

   task automatic t_threshold();
      reg_wr(`TRC_OFF_MODE, 8'h40);
      sample(8'hC5, 8'h00);
      tick(10);
      `CHK(i_host.got.size(), 0)
      sample(8'hC4, 8'h00);
      check_pens(1, 4'h1);
      lift();
   endtask

   task automatic t_modes();
      int       cnt[6] = '{0, 1, 1, 2, 3, 2};
      logic [3:0] pat[6] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2};
      for (int c = 0; c < 6; c++) begin
         reg_wr(`TRC_OFF_MODE, {c[2:0], 2'b00, c[2:0]});
         sample(8'h10, 8'h00);
         check_pens(cnt[c], pat[c]);
         sample(8'hFF, 8'h00);
         check_pens(cnt[c], pat[c]);
      end
      for (int m = 0; m < 3; m++) begin
         reg_wr(`TRC_OFF_MODE, {3'b000, m[1:0], 3'b000});
         sample(8'h10, 8'h00);
         sample(8'h20, 8'h00);
         sample(8'h30, 8'h00);
         check_pens((m == 0) ? 0 : 2, (m == 2) ? 4'h3 : 4'h0);
         lift();
      end
   endtask

   task automatic t_stream();
      int i;
      slow = 1'b1;
      reg_wr(`TRC_OFF_MODE, 8'hB1);
      sample(8'h10, 8'h00);
      wait_rpt(2);
      sample(8'h20, 8'h00);
      // Slow host takes up to three cycles; let it drain before the next sample
      tick(3);
      sample(8'h30, 8'h00);
      check_pens(4, 4'hE);
      sample(8'hFF, 8'h00);
      for (i = 0; i < 500 && i_host.got.size() < 1; i++) tick(1);
      `CHK(i >= 2 * DEB_UNIT - 2, 1'b1)
      check_pens(1, 4'h0);
      slow = 1'b0;
   endtask

   task automatic t_bounce();
      reg_wr(`TRC_OFF_MODE, 8'h51);
      sample(8'h10, 8'h00);
      wait_rpt(1);
      sample(8'hFF, 8'h00);
      sample(8'h10, 8'h00);
      tick(2 * DEB_UNIT + 20);
      `CHK(i_host.got.size(), 1)
      foreach (i_host.got[i]) `CHK(i_host.got[i], 1'b1)
      sample(8'hFF, 8'h00);
      i_host.got.delete();
      check_pens(1, 4'h0);
   endtask

   task automatic t_sleep();
      int i;
      reg_wr(`TRC_OFF_MODE, 8'h40);
      reg_wr(`TRC_OFF_SLEEP, 8'h02);
      for (i = 0; i < 200 && asleep !== 1'b1; i++) tick(1);
      `CHK(i >= 2 * SLEEP_UNIT - 3 && i <= 2 * SLEEP_UNIT + 2, 1'b1)
      reg_rd(`TRC_OFF_SLEEP, d);
      `CHK(asleep, 1'b0)
      for (i = 0; i < 200 && asleep !== 1'b1; i++) tick(1);
      `CHK(asleep, 1'b1)
      sample(8'h10, 8'h00);
      `CHK(asleep, 1'b0)
      check_pens(1, 4'h1);
      lift();
      reg_wr(`TRC_OFF_SLEEP, 8'h00);
      tick(300);
      `CHK(asleep, 1'b0)
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_reset();
      reg_wr(`TRC_OFF_DEBOUNCE, 8'h02);
      t_option();
      t_speed();
      t_threshold();
      t_modes();
      t_stream();
      t_bounce();
      t_sleep();
      conclude();
   end
endmodule
`default_nettype wire
